// ---- include/asp9_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the serial port
// Behaviour
// - Transmit bytes least significant bit first
// - Receive bytes least significant bit first
// - One buffer address: write transmits, read receives
// - Buffer write alone starts a frame
// - Transmit and receive run independently
// - Source bit picks timer 1 or generator
// - Timer 1 rate uses 384 and 192
// - Generator rate uses 64 and 1024
// - Reload value is ten bits, two registers
// - Doubler bit lives in power control
// - Mode 1: start, eight data, stop
// - Mode 2: nine bits, clock/32 or /64
// - Mode 3: nine bits, variable rate
// - Ninth bit sent from control, stored received
// - Three samples mid bit, tolerate 3.5%
// - Multiprocessor modes 2 and 3: flag only ninth=1
// - Rate 300 to 38400, partner matches
// - Hardware sets done flags, software clears
// - Writing one to flags does nothing
// - Mode 1 without multiproc: stop into ninth
`ifndef ASP9_REGS_SVH
`define ASP9_REGS_SVH
`define ASP9_POWER_CTRL_ADDR 8'h87
`define ASP9_SERIAL_CTRL_ADDR 8'h98
`define ASP9_SERIAL_BUF_ADDR 8'h99
`define ASP9_RELOAD_LO_ADDR 8'hAA
`define ASP9_RELOAD_HI_ADDR 8'hBA
`define ASP9_BAUD_SRC_ADDR 8'hD8
`define ASP9_CTRL_MODE_HI 7
`define ASP9_CTRL_MODE_LO 6
`define ASP9_CTRL_MP 5
`define ASP9_CTRL_REN 4
`define ASP9_CTRL_TB8 3
`define ASP9_CTRL_RB8 2
`define ASP9_CTRL_TI 1
`define ASP9_CTRL_RI 0
`define ASP9_DOUBLER_BIT 7
`define ASP9_SRC_BIT 7
`define ASP9_BUF_RST 8'h00
`define ASP9_RELOAD_LO_RST 8'hD9
`define ASP9_RELOAD_HI_RST 2'h3
`define ASP9_MODE_OFF 2'h0
`define ASP9_MODE_8BIT 2'h1
`define ASP9_MODE_FIXED 2'h2
`define ASP9_MODE_VAR9 2'h3
`define ASP9_PH_SAMPLE_A 4'h7
`define ASP9_PH_SAMPLE_B 4'h8
`define ASP9_PH_VOTE 4'h9
`define ASP9_PH_LAST 4'hF
`define ASP9_LAST_DATA 4'h7
`define ASP9_NINTH_IDX 4'h8
`define ASP9_TX_BITS8 4'h9
`define ASP9_TX_BITS9 4'hA
`define ASP9_GEN_TOP 10'h3FF
`endif

// ---- include/asp9_pkg.sv ----
// Types shared by the serial port files
package asp9_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asp9_sfr_req_s;
   typedef logic [1:0] asp9_mode_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp9_rx_state_e;
   typedef enum logic {TX_IDLE, TX_SHIFT} asp9_tx_state_e;
endpackage

// ---- src/asp9_baud_gen.sv ----
// Oversampling tick source: timer 1, reload generator or fixed rate
`include "asp9_regs.svh"

module asp9_baud_gen
   import asp9_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic smod_i,
   input wire logic internal_i,
   input wire logic fixed_i,
   input wire logic [9:0] reload_i,
   input wire logic timer1_ovf_i,
   output logic tick16_o
);
   logic [1:0] pre_r;
   logic [9:0] gen_r;
   logic half_r;
   logic tick_r;
   logic pre_en_w;
   logic gen_ovf_w;
   logic t1_tick_w;
   logic tick_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Doubler shortens the prescale to /2 from /4
   assign pre_en_w = smod_i ? pre_r[0] : (pre_r == 2'h3);
   // Counts reload..top, so 1024 minus reload steps
   assign gen_ovf_w = pre_en_w && (gen_r == `ASP9_GEN_TOP);
   // Two overflows per tick unless doubled: 12 * 32 = 384
   assign t1_tick_w = timer1_ovf_i && (smod_i || half_r);
   // Fixed rate: sixteen ticks a bit gives 64 or 32 clocks per bit
   assign tick_nxt = fixed_i ? pre_en_w : (internal_i ? gen_ovf_w : t1_tick_w);
   // Firmware keeps the rate in 300..38400 bps
   assign tick16_o = tick_r;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pre_r <= 2'h0;
         gen_r <= 10'h000;
         half_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else
      begin
         pre_r <= pre_r + 2'h1;
         if (pre_en_w)
            gen_r <= gen_ovf_w ? reload_i : gen_r + 10'h001;
         if (timer1_ovf_i)
            half_r <= ~half_r;
         tick_r <= tick_nxt;
      end
   end
endmodule

// ---- src/asp9_tx.sv ----
// Transmit shifter: start, data, optional ninth bit, stop
`include "asp9_regs.svh"

module asp9_tx
   import asp9_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic tick16_i,
   input wire logic start_i,
   input wire logic nine_i,
   input wire logic [8:0] data_i,
   output logic tx_o,
   output logic busy_o,
   output logic done_o
);
   asp9_tx_state_e state_r, state_nxt;
   logic [9:0] shreg_r, shreg_nxt;
   logic [3:0] phase_r, phase_nxt;
   logic [3:0] left_r, left_nxt;
   logic tx_r, tx_nxt;
   logic done_r, done_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_nxt = state_r;
      shreg_nxt = shreg_r;
      phase_nxt = tick16_i ? phase_r + 4'h1 : phase_r;
      left_nxt = left_r;
      tx_nxt = tx_r;
      done_nxt = 1'b0;
      case (state_r)
         TX_IDLE:
         begin
            tx_nxt = 1'b1;
            if (start_i)
            begin
               state_nxt = TX_SHIFT;
               tx_nxt = 1'b0;
               phase_nxt = 4'h0;
               shreg_nxt = {1'b1, nine_i ? data_i[8] : 1'b1, data_i[7:0]};
               left_nxt = nine_i ? `ASP9_TX_BITS9 : `ASP9_TX_BITS8;
            end
         end
         TX_SHIFT:
         begin
            if (tick16_i && phase_r == `ASP9_PH_LAST)
            begin
               if (left_r == 4'h0)
               begin
                  state_nxt = TX_IDLE;
                  done_nxt = 1'b1;
               end
               else
               begin
                  tx_nxt = shreg_r[0];
                  shreg_nxt = {1'b1, shreg_r[9:1]};
                  left_nxt = left_r - 4'h1;
               end
            end
         end
         default: state_nxt = TX_IDLE;
      endcase
   end

   assign tx_o = tx_r;
   assign busy_o = (state_r == TX_SHIFT);
   assign done_o = done_r;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_r <= TX_IDLE;
         shreg_r <= 10'h3FF;
         phase_r <= 4'h0;
         left_r <= 4'h0;
         tx_r <= 1'b1;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         shreg_r <= shreg_nxt;
         phase_r <= phase_nxt;
         left_r <= left_nxt;
         tx_r <= tx_nxt;
         done_r <= done_nxt;
      end
   end
endmodule

// ---- src/asp9_serial_port.sv ----
// Serial port top: register slots, receiver, flag handling and checks
`include "asp9_regs.svh"

module asp9_serial_port
   import asp9_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire asp9_sfr_req_s sfr_req_i,
   input wire logic timer1_ovf_i,
   input wire logic rx_pin_i,
   output logic tx_pin_o,
   output logic tx_done_flag_o,
   output logic rx_done_flag_o,
   output logic [7:0] sfr_rdata_o
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic asp9_hit(input logic [7:0] a, input logic [7:0] slot);
      return a == slot;
   endfunction

   function automatic logic asp9_maj3(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   asp9_mode_t mode_r;
   logic multiproc_enable_r;
   logic rx_enable_r;
   logic tx_ninth_bit_r;
   logic rx_ninth_bit_r, rx_ninth_bit_nxt;
   logic tx_done_r, tx_done_nxt;
   logic rx_done_r, rx_done_nxt;
   logic smod_r;
   logic baud_src_r;
   logic [7:0] reload_lo_r;
   logic [1:0] reload_hi_r;
   logic [7:0] rx_buf_r;
   logic [7:0] rdata_r;
   logic rx_meta_r;
   logic rx_sync_r;
   asp9_rx_state_e rx_state_r, rx_state_nxt;
   logic [3:0] rx_phase_r, rx_phase_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt;
   logic [7:0] rx_shreg_r, rx_shreg_nxt;
   logic [1:0] rx_samp_r, rx_samp_nxt;
   logic rx_bit9_r, rx_bit9_nxt;

   logic [7:0] wd_w;
   logic wr_ctrl_w;
   logic wr_buf_w;
   logic wr_power_w;
   logic wr_src_w;
   logic wr_lo_w;
   logic wr_hi_w;
   logic [7:0] ctrl_rd_w;
   logic [7:0] rd_mux_w;
   logic tick16_w;
   logic nine_w;
   logic port_on_w;
   logic fixed_rate_w;
   logic tx_start_w;
   logic tx_busy_w;
   logic tx_done_evt_w;
   logic at_a_w;
   logic at_b_w;
   logic at_vote_w;
   logic at_end_w;
   logic vote_w;
   logic [3:0] last_cnt_w;
   logic bit9_w;
   logic rx_load_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   assign wd_w = sfr_req_i.wdata;
   assign wr_ctrl_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_SERIAL_CTRL_ADDR);
   assign wr_buf_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_SERIAL_BUF_ADDR);
   assign wr_power_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_POWER_CTRL_ADDR);
   assign wr_src_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_BAUD_SRC_ADDR);
   assign wr_lo_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_RELOAD_LO_ADDR);
   assign wr_hi_w = sfr_req_i.wr && asp9_hit(sfr_req_i.addr, `ASP9_RELOAD_HI_ADDR);
   assign ctrl_rd_w = {mode_r, multiproc_enable_r, rx_enable_r,
                       tx_ninth_bit_r, rx_ninth_bit_r, tx_done_r, rx_done_r};
   // Shared slots such as power control read back only the bits kept here
   assign rd_mux_w =
      asp9_hit(sfr_req_i.addr, `ASP9_SERIAL_BUF_ADDR) ? rx_buf_r :
      asp9_hit(sfr_req_i.addr, `ASP9_SERIAL_CTRL_ADDR) ? ctrl_rd_w :
      asp9_hit(sfr_req_i.addr, `ASP9_POWER_CTRL_ADDR) ? {smod_r, 7'h00} :
      asp9_hit(sfr_req_i.addr, `ASP9_BAUD_SRC_ADDR) ? {baud_src_r, 7'h00} :
      asp9_hit(sfr_req_i.addr, `ASP9_RELOAD_LO_ADDR) ? reload_lo_r :
      asp9_hit(sfr_req_i.addr, `ASP9_RELOAD_HI_ADDR) ? {6'h00, reload_hi_r} : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode and transmit start
   assign nine_w = mode_r[1];
   assign port_on_w = (mode_r != `ASP9_MODE_OFF);
   assign fixed_rate_w = (mode_r == `ASP9_MODE_FIXED);
   // A write during a frame is dropped; no second buffer stage
   assign tx_start_w = wr_buf_w && port_on_w && !tx_busy_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive timing and decisions
   assign at_a_w = tick16_w && (rx_phase_r == `ASP9_PH_SAMPLE_A);
   assign at_b_w = tick16_w && (rx_phase_r == `ASP9_PH_SAMPLE_B);
   assign at_vote_w = tick16_w && (rx_phase_r == `ASP9_PH_VOTE);
   assign at_end_w = tick16_w && (rx_phase_r == `ASP9_PH_LAST);
   assign vote_w = asp9_maj3(rx_samp_r[0], rx_samp_r[1], rx_sync_r);
   assign last_cnt_w = nine_w ? `ASP9_NINTH_IDX : `ASP9_LAST_DATA;
   // Ninth data bit in 9-bit modes, else the stop bit
   assign bit9_w = nine_w ? rx_bit9_r : vote_w;
   // Set receive flag blocks the next frame; the address filter needs ninth=1
   assign rx_load_w = (rx_state_r == RX_STOP) && at_vote_w && rx_enable_r
                      && !rx_done_r && (!multiproc_enable_r || bit9_w);

   // Hardware set wins over a same-cycle software clear; ones are ignored
   assign tx_done_nxt = (tx_done_r && !(wr_ctrl_w && !wd_w[`ASP9_CTRL_TI]))
                        || tx_done_evt_w;
   assign rx_done_nxt = (rx_done_r && !(wr_ctrl_w && !wd_w[`ASP9_CTRL_RI]))
                        || rx_load_w;
   assign rx_ninth_bit_nxt = rx_load_w ? bit9_w :
                             (wr_ctrl_w ? wd_w[`ASP9_CTRL_RB8] : rx_ninth_bit_r);

   always_comb
   begin
      rx_state_nxt = rx_state_r;
      rx_phase_nxt = tick16_w ? rx_phase_r + 4'h1 : rx_phase_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_shreg_nxt = rx_shreg_r;
      rx_bit9_nxt = rx_bit9_r;
      rx_samp_nxt = rx_samp_r;
      if (at_a_w)
         rx_samp_nxt[0] = rx_sync_r;
      if (at_b_w)
         rx_samp_nxt[1] = rx_sync_r;
      case (rx_state_r)
         RX_IDLE:
         begin
            // Falling edge restarts the bit clock phase
            if (rx_enable_r && port_on_w && !rx_sync_r)
            begin
               rx_state_nxt = RX_START;
               rx_phase_nxt = 4'h0;
            end
         end
         RX_START:
         begin
            // Glitch shorter than half a bit is a false start
            if (at_vote_w && vote_w)
               rx_state_nxt = RX_IDLE;
            else if (at_end_w)
            begin
               rx_state_nxt = RX_DATA;
               rx_cnt_nxt = 4'h0;
            end
         end
         RX_DATA:
         begin
            if (at_vote_w)
            begin
               if (rx_cnt_r == `ASP9_NINTH_IDX)
                  rx_bit9_nxt = vote_w;
               else
                  rx_shreg_nxt = {vote_w, rx_shreg_r[7:1]};
            end
            if (at_end_w)
            begin
               if (rx_cnt_r == last_cnt_w)
                  rx_state_nxt = RX_STOP;
               else
                  rx_cnt_nxt = rx_cnt_r + 4'h1;
            end
         end
         RX_STOP:
         begin
            // Back to idle mid stop bit to catch an early next start
            if (at_vote_w)
               rx_state_nxt = RX_IDLE;
         end
         default: rx_state_nxt = RX_IDLE;
      endcase
      if (!rx_enable_r)
         rx_state_nxt = RX_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mode_r <= `ASP9_MODE_OFF;
         multiproc_enable_r <= 1'b0;
         rx_enable_r <= 1'b0;
         tx_ninth_bit_r <= 1'b0;
         smod_r <= 1'b0;
         baud_src_r <= 1'b0;
         reload_lo_r <= `ASP9_RELOAD_LO_RST;
         reload_hi_r <= `ASP9_RELOAD_HI_RST;
      end
      else
      begin
         if (wr_ctrl_w)
         begin
            mode_r <= wd_w[`ASP9_CTRL_MODE_HI:`ASP9_CTRL_MODE_LO];
            multiproc_enable_r <= wd_w[`ASP9_CTRL_MP];
            rx_enable_r <= wd_w[`ASP9_CTRL_REN];
            tx_ninth_bit_r <= wd_w[`ASP9_CTRL_TB8];
         end
         if (wr_power_w)
            smod_r <= wd_w[`ASP9_DOUBLER_BIT];
         if (wr_src_w)
            baud_src_r <= wd_w[`ASP9_SRC_BIT];
         if (wr_lo_w)
            reload_lo_r <= wd_w;
         if (wr_hi_w)
            reload_hi_r <= wd_w[1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tx_done_r <= 1'b0;
         rx_done_r <= 1'b0;
         rx_ninth_bit_r <= 1'b0;
         rx_buf_r <= `ASP9_BUF_RST;
         rdata_r <= 8'h00;
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end
      else
      begin
         tx_done_r <= tx_done_nxt;
         rx_done_r <= rx_done_nxt;
         rx_ninth_bit_r <= rx_ninth_bit_nxt;
         if (rx_load_w)
            rx_buf_r <= rx_shreg_r;
         rdata_r <= sfr_req_i.rd ? rd_mux_w : 8'h00;
         rx_meta_r <= rx_pin_i;
         rx_sync_r <= rx_meta_r;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rx_state_r <= RX_IDLE;
         rx_phase_r <= 4'h0;
         rx_cnt_r <= 4'h0;
         rx_shreg_r <= 8'h00;
         rx_samp_r <= 2'h3;
         rx_bit9_r <= 1'b0;
      end
      else
      begin
         rx_state_r <= rx_state_nxt;
         rx_phase_r <= rx_phase_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_shreg_r <= rx_shreg_nxt;
         rx_samp_r <= rx_samp_nxt;
         rx_bit9_r <= rx_bit9_nxt;
      end
   end

   assign tx_done_flag_o = tx_done_r;
   assign rx_done_flag_o = rx_done_r;
   assign sfr_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   asp9_baud_gen u_baud (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .smod_i(smod_r),
      .internal_i(baud_src_r),
      .fixed_i(fixed_rate_w),
      .reload_i({reload_hi_r, reload_lo_r}),
      .timer1_ovf_i(timer1_ovf_i),
      .tick16_o(tick16_w)
   );

   // Separate shifter keeps sending while the receiver works
   asp9_tx u_tx (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .tick16_i(tick16_w),
      .start_i(tx_start_w),
      .nine_i(nine_w),
      .data_i({tx_ninth_bit_r, wd_w}),
      .tx_o(tx_pin_o),
      .busy_o(tx_busy_w),
      .done_o(tx_done_evt_w)
   );

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_tx_idle_high;
      !tx_busy_w |-> tx_pin_o;
   endproperty
   a_tx_idle_high: assert property (p_tx_idle_high)
      else $error("line not high while idle");

   property p_tx_start;
      tx_start_w |=> tx_busy_w && !tx_pin_o;
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("buffer write did not start a frame");

   property p_tx_flag_set;
      tx_done_evt_w |=> tx_done_r;
   endproperty
   a_tx_flag_set: assert property (p_tx_flag_set)
      else $error("transmit flag not set");

   property p_one_ignored;
      wr_ctrl_w && wd_w[`ASP9_CTRL_TI] && !tx_done_r && !tx_done_evt_w |=> !tx_done_r;
   endproperty
   a_one_ignored: assert property (p_one_ignored)
      else $error("writing one set the flag");

   property p_set_wins;
      rx_load_w && wr_ctrl_w && !wd_w[`ASP9_CTRL_RI] |=> rx_done_r;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("receive event lost to clear");

   property p_rx_load;
      rx_load_w |=> rx_done_r && rx_buf_r == $past(rx_shreg_r);
   endproperty
   a_rx_load: assert property (p_rx_load)
      else $error("received byte not stored");

   property p_rx_shift;
      rx_state_r == RX_DATA && at_vote_w && rx_cnt_r != `ASP9_NINTH_IDX
         |=> rx_shreg_r == {$past(vote_w), $past(rx_shreg_r[7:1])};
   endproperty
   a_rx_shift: assert property (p_rx_shift)
      else $error("receive shift order wrong");

   property p_mp_filter;
      rx_load_w && mode_r == `ASP9_MODE_VAR9 && multiproc_enable_r |-> rx_bit9_r;
   endproperty
   a_mp_filter: assert property (p_mp_filter)
      else $error("frame with ninth bit zero flagged");

   property p_ninth_store;
      rx_load_w && nine_w |=> rx_ninth_bit_r == $past(rx_bit9_r);
   endproperty
   a_ninth_store: assert property (p_ninth_store)
      else $error("ninth bit not stored");

   property p_stop_store;
      rx_load_w && mode_r == `ASP9_MODE_8BIT |=> rx_ninth_bit_r == $past(vote_w);
   endproperty
   a_stop_store: assert property (p_stop_store)
      else $error("stop bit not stored");

   property p_rx_off;
      !rx_enable_r |=> rx_state_r == RX_IDLE && !rx_load_w;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("receiving while disabled");

   property p_false_start;
      rx_state_r == RX_START && at_vote_w && vote_w |=> rx_state_r == RX_IDLE;
   endproperty
   a_false_start: assert property (p_false_start)
      else $error("false start not rejected");

   property p_frame_len;
      rx_enable_r && rx_state_r == RX_DATA && at_end_w && rx_cnt_r == `ASP9_LAST_DATA
         |=> rx_state_r == (nine_w ? RX_DATA : RX_STOP);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame length wrong for mode");

   c_tx_done: cover property (tx_done_evt_w);
   c_duplex: cover property (tx_busy_w && rx_load_w);
   c_mp_load: cover property (rx_load_w && multiproc_enable_r && nine_w);
   c_false_start: cover property (rx_state_r == RX_START && at_vote_w && vote_w);
endmodule

// ---- verification/asp9_line_model.sv ----
// Far-end serial line model for the serial port
module asp9_line_model (
   input wire logic clk_sys_i,
   input wire logic line_in_i,
   output logic line_out_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pulled-up line rests high between frames
   initial line_out_o = 1'b1;

   // Bit order and period set by caller; both ends share the rate
   task automatic send(input logic [10:0] frame, input int nbits, input int period);
      for (int i = 0; i < nbits; i++)
      begin
         line_out_o <= frame[i];
         repeat (period) @(posedge clk_sys_i);
      end
      line_out_o <= 1'b1;
   endtask

   // Mid-bit sampling; start edge seen to within one clock
   task automatic recv(output logic [10:0] frame, input int nbits, input int period);
      int w;
      frame = '0;
      w = 0;
      while (line_in_i !== 1'b0 && w < 200)
      begin
         @(posedge clk_sys_i);
         w++;
      end
      repeat (period / 2) @(posedge clk_sys_i);
      for (int i = 0; i < nbits; i++)
      begin
         frame[i] = line_in_i;
         repeat (period) @(posedge clk_sys_i);
      end
   endtask
endmodule

// ---- verification/asp9_serial_port_bench.sv ----
// Bench for the serial port: register checks and full-duplex frames
module asp9_serial_port_bench
   import asp9_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   asp9_sfr_req_s req = '0;
   logic t1_ovf = 1'b0;
   int t1c = 0;
   logic rx_line;
   logic tx_line;
   logic tx_flag;
   logic rx_flag;
   logic [7:0] rdata;
   logic [10:0] got;
   int fails = 0;
   int checked = 0;
   logic [7:0] rs_a [5] = '{8'hAA, 8'hBA, 8'h98, 8'h99, 8'h55};
   logic [7:0] rs_v [5] = '{8'hD9, 8'h03, 8'h00, 8'h00, 8'h00};
   // Per case: control, doubler, source, reload, bit period, ninth or stop sent
   logic [7:0] cf_ctl [6] = '{8'h50, 8'h98, 8'hD0, 8'hF8, 8'hF8, 8'h40};
   logic [7:0] cf_pc [6] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80};
   logic [7:0] cf_src [6] = '{8'h80, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
   logic [9:0] cf_rel [6] = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h3FE, 10'h3FE, 10'h3FF};
   int cf_per [6] = '{32, 64, 64, 128, 128, 32};
   logic cf_n9 [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   always #5 clk_sys_i = ~clk_sys_i;

   // Timer 1 overflow every fourth clock
   always @(posedge clk_sys_i)
   begin
      t1c <= (t1c + 1) % 4;
      t1_ovf <= (t1c == 0);
   end

   asp9_serial_port u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sfr_req_i(req),
      .timer1_ovf_i(t1_ovf), .rx_pin_i(rx_line), .tx_pin_o(tx_line),
      .tx_done_flag_o(tx_flag), .rx_done_flag_o(rx_flag), .sfr_rdata_o(rdata));
   asp9_line_model u_line (.clk_sys_i(clk_sys_i), .line_in_i(tx_line), .line_out_o(rx_line));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      req <= '0;
   endtask

   // Data is registered at the edge that takes the read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      req <= '0;
      #1 d = rdata;
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [7:0] v;
      logic [7:0] dt;
      logic [7:0] dr;
      logic nine;
      logic exp_rx;
      time t0;
      time t1;
      int nb;
      void'($urandom(32'haafc_85e9));
      repeat (8) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      chk(tx_line, 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         rd(rs_a[i], v);
         chk(v, rs_v[i]);
      end
      for (int c = 0; c < 6; c++)
      begin
         nine = cf_ctl[c][7];
         exp_rx = cf_ctl[c][4] && !(cf_ctl[c][5] && !cf_n9[c]);
         dt = 8'($urandom);
         dr = 8'($urandom);
         wr(8'h87, cf_pc[c]);
         wr(8'hD8, cf_src[c]);
         wr(8'hAA, cf_rel[c][7:0]);
         wr(8'hBA, {6'h00, cf_rel[c][9:8]});
         wr(8'h98, cf_ctl[c]);
         // Generator climbs from zero once after reset before its first tick
         if (c == 0)
            repeat (2200) @(posedge clk_sys_i);
         t0 = $time;
         // Both directions at once; address frames carry ninth bit set
         fork
            wr(8'h99, dt);
            u_line.recv(got, nine ? 11 : 10, cf_per[c]);
            u_line.send({1'b1, cf_n9[c], dr, 1'b0}, nine ? 11 : 10, cf_per[c]);
            begin
               wait (tx_flag === 1'b1);
               t1 = $time;
            end
         join
         repeat (8) @(posedge clk_sys_i);
         chk(got, nine ? {1'b1, cf_ctl[c][3], dt, 1'b0} : {2'b01, dt, 1'b0});
         // Frame time from write to flag, in whole bit periods
         nb = int'(((t1 - t0) / 10 + cf_per[c] / 2) / cf_per[c]);
         chk(11'(nb), nine ? 11'h00B : 11'h00A);
         chk(tx_flag, 1'b1);
         chk(rx_flag, exp_rx);
         rd(8'h98, v);
         if (exp_rx)
         begin
            chk(v[2], cf_n9[c]);
            rd(8'h99, v);
            chk(v, dr);
         end
         wr(8'h98, cf_ctl[c] & 8'hFC);
         wr(8'h98, cf_ctl[c] | 8'h03);
         @(posedge clk_sys_i);
         chk({tx_flag, rx_flag}, 2'b00);
      end
      summarize();
   end

   // Whole run is about 7.5k clocks; generous margin for a hang
   initial
   begin
      #300_000;
      fails++;
      summarize();
   end
endmodule
